/* verilog/ilcd_top.sv */
// Chosen here: the APB register port.
`timescale 1ns/10ps
module ilcd_top #(
    parameter int SEC_COUNT_T1   = ilcd_pkg::RATE_T1_HZ,
    parameter int SEC_COUNT_E1   = ilcd_pkg::RATE_E1_HZ,
    parameter int INTEG_COUNT_T1 =
        ilcd_pkg::RATE_T1_HZ / ilcd_pkg::MS_PER_S * ilcd_pkg::INTEG_TIME_MS,
    parameter int INTEG_COUNT_E1 =
        ilcd_pkg::RATE_E1_HZ / ilcd_pkg::MS_PER_S * ilcd_pkg::INTEG_TIME_MS
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        rx_bit_clk_i,
    input  wire logic        rx_data_i,
    input  wire logic [3:0]  rx_level_i,
    input  wire logic        tx_bit_clk_i,
    output logic             tx_code_o,
    output logic             tx_insert_o,
    output logic             remote_loopback_o,
    output logic             irq_o
);
    import ilcd_pkg::*;

    localparam logic [23:0] SEC_LAST_T1   = 24'(SEC_COUNT_T1 - 1);
    localparam logic [23:0] SEC_LAST_E1   = 24'(SEC_COUNT_E1 - 1);
    localparam logic [23:0] INTEG_LAST_T1 = 24'(INTEG_COUNT_T1 - 1);
    localparam logic [23:0] INTEG_LAST_E1 = 24'(INTEG_COUNT_E1 - 1);
    logic [7:0]       len_ctrl;
    logic [7:0]       ctrl;
    logic [7:0]       tx_pat_low;
    logic [7:0]       tx_pat_high;
    logic [7:0]       det_pat_low  [2];
    logic [7:0]       det_pat_high [2];
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_enable;
    logic [INT_W-1:0] int_set;
    logic             sec_flag;
    logic             arl_flag;
    logic [2:0]       arl_cnt;
    logic [23:0]      sec_cnt;
    logic             sec_tick;
    logic [2:0]       rx_clk_sync;
    logic [1:0]       rx_dat_sync;
    logic [3:0]       lvl_meta;
    logic [3:0]       lvl_sync;
    logic [2:0]       tx_clk_sync;
    logic [4:0]       tx_phase;
    logic [4:0]       tx_len;
    logic [1:0]       det_lock;
    logic             rx_stb;
    logic             tx_stb;
    logic             acc_done;
    logic             wr_en;
    logic             rd_info;
    logic [5:0]       widx;
    logic [31:0]      next_prdata;
    logic             next_slverr;
    logic [15:0]      tx_pattern;
    // Pins sampled by two flops before any logic looks at them
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_clk_sync <= 3'h0;
            rx_dat_sync <= 2'h0;
            tx_clk_sync <= 3'h0;
            lvl_meta    <= 4'h0;
            lvl_sync    <= 4'h0;
        end else begin
            rx_clk_sync <= {rx_clk_sync[1:0], rx_bit_clk_i};
            rx_dat_sync <= {rx_dat_sync[0], rx_data_i};
            tx_clk_sync <= {tx_clk_sync[1:0], tx_bit_clk_i};
            lvl_meta    <= rx_level_i;
            lvl_sync    <= lvl_meta;
        end
    end

    assign rx_stb = rx_clk_sync[1] & ~rx_clk_sync[2];
    assign tx_stb = tx_clk_sync[1] & ~tx_clk_sync[2];
    // APB: answer prepared in setup, access completes one cycle later
    assign acc_done = psel_i & penable_i & pready_o;
    assign wr_en    = acc_done & pwrite_i & ~pslverr_o;
    assign rd_info  = acc_done & ~pwrite_i & (paddr_i[7:2] == IDX_RX_INFO_TWO);
    assign widx     = paddr_i[7:2];

    always_comb begin
        next_prdata = 32'h0;
        next_slverr = 1'b0;
        case (widx)
            IDX_RX_INFO_TWO: next_prdata[7:0] = {lvl_sync, 2'b00, arl_flag, sec_flag};
            IDX_LEN_CTRL:    next_prdata[7:0] = len_ctrl;
            IDX_TX_PAT_LOW:  next_prdata[7:0] = tx_pat_low;
            IDX_TX_PAT_HIGH: next_prdata[7:0] = tx_pat_high;
            IDX_UP_PAT_LOW:  next_prdata[7:0] = det_pat_low[0];
            IDX_UP_PAT_HIGH: next_prdata[7:0] = det_pat_high[0];
            IDX_DN_PAT_LOW:  next_prdata[7:0] = det_pat_low[1];
            IDX_DN_PAT_HIGH: next_prdata[7:0] = det_pat_high[1];
            IDX_CTRL:        next_prdata[7:0] = ctrl;
            IDX_INT_STATUS:  next_prdata[INT_W-1:0] = int_status;
            IDX_INT_CLEAR:   next_prdata = 32'h0;
            IDX_INT_ENABLE:  next_prdata[INT_W-1:0] = int_enable;
            default:         next_slverr = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prdata_o  <= 32'h0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & next_slverr;
            prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? next_prdata : 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            len_ctrl        <= LEN_CTRL_RST;
            ctrl            <= CTRL_RST;
            tx_pat_low      <= PAT_RST;
            tx_pat_high     <= PAT_RST;
            det_pat_low[0]  <= PAT_RST;
            det_pat_high[0] <= PAT_RST;
            det_pat_low[1]  <= PAT_RST;
            det_pat_high[1] <= PAT_RST;
            int_enable      <= INT_EN_RST;
        end else if (wr_en) begin
            case (widx)
                IDX_LEN_CTRL:    len_ctrl        <= pwdata_i[7:0];
                IDX_TX_PAT_LOW:  tx_pat_low      <= pwdata_i[7:0];
                IDX_TX_PAT_HIGH: tx_pat_high     <= pwdata_i[7:0];
                IDX_UP_PAT_LOW:  det_pat_low[0]  <= pwdata_i[7:0];
                IDX_UP_PAT_HIGH: det_pat_high[0] <= pwdata_i[7:0];
                IDX_DN_PAT_LOW:  det_pat_low[1]  <= pwdata_i[7:0];
                IDX_DN_PAT_HIGH: det_pat_high[1] <= pwdata_i[7:0];
                IDX_CTRL:        ctrl            <= pwdata_i[7:0];
                IDX_INT_ENABLE:  int_enable      <= pwdata_i[INT_W-1:0];
                default:         ctrl            <= ctrl;
            endcase
        end
    end

    // second counter on recovered clock, restarts at tick
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sec_cnt  <= 24'h0;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= 1'b0;
            if (rx_stb) begin
                if (sec_cnt >= (ctrl[CTRL_E1] ? SEC_LAST_E1 : SEC_LAST_T1)) begin
                    sec_cnt  <= 24'h0;
                    sec_tick <= 1'b1;
                end else begin
                    sec_cnt <= sec_cnt + 24'h1;
                end
            end
        end
    end

    // read clears reported tick; a tick after setup survives
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sec_flag <= 1'b0;
        end else if (sec_tick) begin
            sec_flag <= 1'b1;
        end else if (rd_info && prdata_o[INFO_SEC]) begin
            sec_flag <= 1'b0;
        end
    end

    // Lengths 2, 4 and 8 share the 16-bit shape; shorter codes repeat in it
    always_comb begin
        case (len_ctrl[LEN_TX_POS +: 2])
            2'b00:   tx_len = 5'd5;
            2'b01:   tx_len = 5'd6;
            2'b10:   tx_len = 5'd7;
            default: tx_len = 5'd16;
        endcase
    end

    // first bit is low register MSB
    assign tx_pattern = {tx_pat_low, tx_pat_high};
    // insert code while enabled, one bit per transmit clock
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tx_phase    <= 5'h0;
            tx_code_o   <= 1'b0;
            tx_insert_o <= 1'b0;
        end else if (!ctrl[CTRL_TX_EN]) begin
            tx_phase    <= 5'h0;
            tx_code_o   <= 1'b0;
            tx_insert_o <= 1'b0;
        end else begin
            tx_insert_o <= 1'b1;
            if (tx_stb) begin
                tx_code_o <= tx_pattern[4'(5'd15 - tx_phase)];
                tx_phase  <= (tx_phase >= tx_len - 5'd1) ? 5'h0 : tx_phase + 5'h1;
            end
        end
    end

    // one detector per code, each with its own settings
    for (genvar g = 0; g < 2; g++) begin : g_det
        ilcd_det_state_t state;
        logic [2:0]      len_f;
        logic [4:0]      len;
        logic [15:0]     pat;
        logic [4:0]      phase;
        logic [23:0]     integ;
        logic [6:0]      blk;
        logic [3:0]      err;
        logic            miss;
        logic            fail;

        assign len_f = (g == 0) ? len_ctrl[LEN_UP_POS +: 3] : len_ctrl[LEN_DN_POS +: 3];
        // 111 selects 16, which also covers 8
        assign len   = (len_f == 3'h7) ? 5'd16 : {2'b00, len_f} + 5'd1;
        // only the first len bits are compared
        assign pat   = {det_pat_low[g], det_pat_high[g]};
        assign miss  = rx_dat_sync[1] != pat[4'(5'd15 - phase)];
        // a few misses per block are tolerated
        assign fail  = (err + {3'b000, miss}) > ERR_LIMIT;

        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                state <= ILCD_HUNT;
                phase <= 5'h0;
                integ <= 24'h0;
                blk   <= 7'h0;
                err   <= 4'h0;
            end else if (rx_stb) begin
                if (fail) begin
                    // restart integration, hold phase to slip one bit
                    state <= ILCD_HUNT;
                    integ <= 24'h0;
                    blk   <= 7'h0;
                    err   <= 4'h0;
                end else begin
                    phase <= (phase >= len - 5'd1) ? 5'h0 : phase + 5'h1;
                    blk   <= blk + 7'h1;
                    err   <= (blk == ERR_BLOCK_LAST) ? 4'h0 : err + {3'b000, miss};
                    case (state)
                        ILCD_HUNT: begin
                            if (integ >= (ctrl[CTRL_E1] ? INTEG_LAST_E1 : INTEG_LAST_T1)) begin
                                state <= ILCD_LOCK;
                            end else begin
                                integ <= integ + 24'h1;
                            end
                        end
                        ILCD_LOCK: state <= ILCD_LOCK;
                        default:   state <= ILCD_HUNT;
                    endcase
                end
            end
        end
        assign det_lock[g] = (state == ILCD_LOCK);
    end

    // whole seconds of continuous code move the flag
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            arl_flag <= 1'b0;
            arl_cnt  <= 3'h0;
        end else if (!ctrl[CTRL_ARL_EN]) begin
            arl_flag <= 1'b0;
            arl_cnt  <= 3'h0;
        end else if (!det_lock[arl_flag]) begin
            arl_cnt <= 3'h0;
        end else if (sec_tick) begin
            if (arl_cnt >= ARL_TIME_S - 3'h1) begin
                arl_flag <= ~arl_flag;
                arl_cnt  <= 3'h0;
            end else begin
                arl_cnt <= arl_cnt + 3'h1;
            end
        end
    end

    always_comb begin
        int_set          = '0;
        // up and down bits set on every cycle their detector is locked
        int_set[INT_UP]  = det_lock[0];
        int_set[INT_DN]  = det_lock[1];
        int_set[INT_SEC] = sec_tick;
        int_set[INT_ARL] = arl_flag != remote_loopback_o;
    end
    // Sticky status; write-one clear, a new event wins over the clear
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            int_status <= '0;
        end else if (wr_en && widx == IDX_INT_CLEAR) begin
            int_status <= (int_status & ~pwdata_i[INT_W-1:0]) | int_set;
        end else begin
            int_status <= int_status | int_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_o             <= 1'b0;
            remote_loopback_o <= 1'b0;
        end else begin
            irq_o             <= |(int_status & int_enable);
            remote_loopback_o <= arl_flag;
        end
    end
endmodule

/* pkg/ilcd_pkg.sv */
package ilcd_pkg;
    // Word indices; byte address is four times the index
    localparam logic [5:0] IDX_RX_INFO_TWO = 6'h09;
    localparam logic [5:0] IDX_LEN_CTRL    = 6'h0a;
    localparam logic [5:0] IDX_TX_PAT_LOW  = 6'h0b;
    localparam logic [5:0] IDX_TX_PAT_HIGH = 6'h0c;
    localparam logic [5:0] IDX_UP_PAT_LOW  = 6'h0d;
    localparam logic [5:0] IDX_UP_PAT_HIGH = 6'h0e;
    localparam logic [5:0] IDX_DN_PAT_LOW  = 6'h0f;
    localparam logic [5:0] IDX_DN_PAT_HIGH = 6'h10;
    localparam logic [5:0] IDX_CTRL        = 6'h20;
    localparam logic [5:0] IDX_INT_STATUS  = 6'h21;
    localparam logic [5:0] IDX_INT_CLEAR   = 6'h22;
    localparam logic [5:0] IDX_INT_ENABLE  = 6'h23;

    // Field positions
    localparam int LEN_TX_POS   = 6;
    localparam int LEN_UP_POS   = 3;
    localparam int LEN_DN_POS   = 0;
    localparam int CTRL_TX_EN   = 0;
    localparam int CTRL_ARL_EN  = 1;
    localparam int CTRL_E1      = 2;
    localparam int INFO_LVL_POS = 4;
    localparam int INFO_ARL     = 1;
    localparam int INFO_SEC     = 0;
    localparam int INT_UP       = 0;
    localparam int INT_DN       = 1;
    localparam int INT_SEC      = 2;
    localparam int INT_ARL      = 3;
    localparam int INT_W        = 4;

    // Values after reset
    localparam logic [7:0]       LEN_CTRL_RST = 8'h00;
    localparam logic [7:0]       CTRL_RST     = 8'h00;
    localparam logic [7:0]       PAT_RST      = 8'h00;
    localparam logic [INT_W-1:0] INT_EN_RST   = 4'h0;

    // Timing
    localparam int RATE_T1_HZ    = 1544000;
    localparam int RATE_E1_HZ    = 2048000;
    localparam int INTEG_TIME_MS = 48;
    localparam int MS_PER_S      = 1000;
    localparam logic [2:0] ARL_TIME_S = 3'h5;

    // Error tolerance: mismatches allowed per block of received bits
    localparam logic [6:0] ERR_BLOCK_LAST = 7'h7f;
    localparam logic [3:0] ERR_LIMIT      = 4'h4;

    typedef enum logic [0:0] {
        ILCD_HUNT = 1'b0,
        ILCD_LOCK = 1'b1
    } ilcd_det_state_t;
endpackage

/* tb/ilcd_asserts.sv */
`timescale 1ns/10ps
module ilcd_asserts
    import ilcd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [31:0] prdata_o,
    input  wire logic        pready_o,
    input  wire logic        pslverr_o,
    input  wire logic        tx_insert_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic [5:0] idx;
    logic       mapped;
    logic       wr_ctrl;
    assign idx     = paddr_i[7:2];
    assign mapped  = (idx >= IDX_RX_INFO_TWO && idx <= IDX_DN_PAT_HIGH) ||
                     (idx >= IDX_CTRL && idx <= IDX_INT_ENABLE);
    assign wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && idx == IDX_CTRL;
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence access_s;
        psel_i && penable_i && pready_o;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> access_s)
        else $error("no ready after setup");
    ready_single_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    ready_in_access_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside access");
    err_map_a: assert property (pready_o && !mapped |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    ok_map_a: assert property (pready_o && mapped |-> !pslverr_o)
        else $error("mapped access refused");
    spare_bits_a: assert property (
        pready_o && !pwrite_i && idx == IDX_RX_INFO_TWO |-> prdata_o[3:2] == 2'h0)
        else $error("spare info bits not zero");
    insert_on_a: assert property (
        $rose(tx_insert_o) |-> $past(wr_ctrl && pwdata_i[CTRL_TX_EN], 2))
        else $error("insert rose without enable write");
    insert_off_a: assert property (
        $fell(tx_insert_o) |-> $past(wr_ctrl && !pwdata_i[CTRL_TX_EN], 2))
        else $error("insert fell without disable write");
endmodule
bind ilcd_top ilcd_asserts ilcd_asserts_inst (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_insert_o);

/* tb/ilcd_line_model.sv */
`timescale 1ns/10ps
module ilcd_line_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] pat_i,
    input  wire logic [4:0]  len_i,
    input  wire logic        err_en_i,
    input  wire logic        tx_code_i,
    output logic             rx_bit_clk_o,
    output logic             rx_data_o,
    output logic             tx_bit_clk_o,
    output logic [31:0]      cap_o,
    output int               bit_cnt_o
);
    logic [3:0] ph  = 4'h0;
    logic [4:0] pos = 5'h00;
    int         err_ctr = 0;
    initial begin
        {rx_bit_clk_o, rx_data_o, tx_bit_clk_o} = 3'h0;
        cap_o = 32'h0;
        bit_cnt_o = 0;
    end
    always @(posedge clk_i) begin
        ph <= ph + 4'h1;
        rx_bit_clk_o <= ph[2];
        tx_bit_clk_o <= ph[3];
        // Data changes half a bit before its edge
        if (ph[2:0] == 3'h0) begin
            pos <= (pos + 5'h01 >= len_i) ? 5'h00 : pos + 5'h01;
            err_ctr <= (err_ctr == 99) ? 0 : err_ctr + 1;
            rx_data_o <= pat_i[5'd15 - pos] ^ (err_en_i && err_ctr == 99);
        end
        if (ph[2:0] == 3'h4) bit_cnt_o <= bit_cnt_o + 1;
        // Old bit taken at tx edge, long settled
        if (ph == 4'h8) cap_o <= {cap_o[30:0], tx_code_i};
    end
endmodule

/* tb/ilcd_top_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module ilcd_top_tb;
    import ilcd_pkg::*;
    localparam int SEC    = 50;
    localparam int SEC_E1 = 60;
    localparam int INTEG  = 40;
    typedef struct packed {
        logic [5:0]  idx;
        logic [31:0] wd;
        logic [31:0] rd;
        logic        err;
    } ilcd_row_t;
    localparam ilcd_row_t ROWS [12] = '{
        '{IDX_LEN_CTRL, 32'ha5, 32'ha5, 1'b0}, '{IDX_TX_PAT_LOW, 32'h3c, 32'h3c, 1'b0},
        '{IDX_TX_PAT_HIGH, 32'hc3, 32'hc3, 1'b0}, '{IDX_UP_PAT_LOW, 32'h5a, 32'h5a, 1'b0},
        '{IDX_UP_PAT_HIGH, 32'h96, 32'h96, 1'b0}, '{IDX_DN_PAT_LOW, 32'h69, 32'h69, 1'b0},
        '{IDX_DN_PAT_HIGH, 32'hf0, 32'hf0, 1'b0}, '{IDX_CTRL, 32'h04, 32'h04, 1'b0},
        '{IDX_INT_ENABLE, 32'hff, 32'h0f, 1'b0}, '{IDX_INT_CLEAR, 32'hff, 32'h00, 1'b0},
        '{6'h11, 32'h77, 32'h00, 1'b1}, '{6'h3f, 32'h77, 32'h00, 1'b1}};
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0]  rx_level_i = 4'h0;
    logic [15:0] pat = 16'hc000;
    logic [4:0]  len = 5'h03;
    logic        err_en = 1'b0;
    logic [31:0] prdata_o, q, cap;
    logic        pready_o, pslverr_o, rx_bit_clk_i, rx_data_i, tx_bit_clk_i, e;
    logic        tx_code_o, tx_insert_o, remote_loopback_o, irq_o;
    int          bit_cnt, b0, error_cnt = 0, checks = 0;
    logic [7:0]  tx_lo [4] = '{8'h80, 8'h8c, 8'h03, 8'h80};
    logic [7:0]  tx_hi [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
    int          tx_per [4] = '{5, 6, 7, 16};
    int          tx_one [4] = '{1, 3, 1, 2};

    always #4 clk_i = ~clk_i;

    ilcd_top #(.SEC_COUNT_T1(SEC), .SEC_COUNT_E1(SEC_E1), .INTEG_COUNT_T1(INTEG),
        .INTEG_COUNT_E1(INTEG)) ilcd_top_inst (.clk_i, .resetn_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_bit_clk_i,
        .rx_data_i, .rx_level_i, .tx_bit_clk_i, .tx_code_o, .tx_insert_o, .remote_loopback_o,
        .irq_o);
    ilcd_line_model ilcd_line_model_inst (.clk_i, .pat_i(pat), .len_i(len),
        .err_en_i(err_en), .tx_code_i(tx_code_o), .rx_bit_clk_o(rx_bit_clk_i),
        .rx_data_o(rx_data_i), .tx_bit_clk_o(tx_bit_clk_i), .cap_o(cap), .bit_cnt_o(bit_cnt));

    task automatic test_done();
        $display("Errors %0d, checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i} <= {2'b10, w};
        {paddr_i, pwdata_i} <= {idx, 2'b00, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        q = prdata_o;
        e = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
        if (n >= 20) begin error_cnt++; test_done(); end
    endtask

    task automatic wait_st(input int b, input int lim);
        int n = 0;
        do begin
            apb(1'b0, IDX_INT_STATUS, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < lim);
        if (n >= lim) begin error_cnt++; test_done(); end
    endtask

    task automatic wait_rl(input logic v);
        int n = 0;
        while (remote_loopback_o !== v && n < 8000) begin @(posedge clk_i); n++; end
        if (n >= 8000) begin error_cnt++; test_done(); end
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        `CHK({pready_o, pslverr_o, tx_code_o, tx_insert_o, remote_loopback_o, irq_o}, 6'h0)
        resetn_i <= 1'b1;
        foreach (ROWS[i]) begin
            apb(1'b0, ROWS[i].idx, 32'h0);
            `CHK({e, q}, {ROWS[i].err, 32'h0})
        end
        foreach (ROWS[i]) begin
            apb(1'b1, ROWS[i].idx, ROWS[i].wd);
            apb(1'b0, ROWS[i].idx, 32'h0);
            `CHK({e, q}, {ROWS[i].err, ROWS[i].rd})
        end
        for (int i = 0; i < 16; i++) begin
            rx_level_i <= 4'(i);
            repeat (4) @(posedge clk_i);
            apb(1'b0, IDX_RX_INFO_TWO, 32'h0);
            `CHK(q[7:4], 4'(i))
            `CHK(q[3:2], 2'h0)
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, IDX_LEN_CTRL, 32'(i) << LEN_TX_POS);
            apb(1'b1, IDX_TX_PAT_LOW, {24'h0, tx_lo[i]});
            apb(1'b1, IDX_TX_PAT_HIGH, {24'h0, tx_hi[i]});
            apb(1'b1, IDX_CTRL, 32'h1);
            repeat (700) @(posedge clk_i);
            `CHK(tx_insert_o, 1'b1)
            `CHK((cap ^ (cap >> tx_per[i])) & (32'hffffffff >> tx_per[i]), 32'h0)
            `CHK($countones(cap & ((32'h1 << tx_per[i]) - 32'h1)), tx_one[i])
        end
        apb(1'b1, IDX_CTRL, 32'h0);
        repeat (100) @(posedge clk_i);
        `CHK({tx_insert_o, tx_code_o}, 2'h0)
        apb(1'b1, IDX_LEN_CTRL, 32'h27);
        apb(1'b1, IDX_UP_PAT_LOW, 32'h87);
        apb(1'b1, IDX_DN_PAT_LOW, 32'hf0);
        apb(1'b1, IDX_DN_PAT_HIGH, 32'h0f);
        apb(1'b1, IDX_INT_ENABLE, 32'h1);
        apb(1'b1, IDX_INT_CLEAR, 32'hf);
        {pat, len, err_en} <= {16'h8000, 5'd5, 1'b1};
        b0 = bit_cnt;
        wait_st(INT_UP, 8000);
        `CHK(bit_cnt - b0 >= INTEG, 1'b1)
        `CHK(q[INT_DN], 1'b0)
        @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        apb(1'b1, IDX_INT_CLEAR, 32'h1);
        apb(1'b0, IDX_INT_STATUS, 32'h0);
        `CHK(q[INT_UP], 1'b1)
        apb(1'b1, IDX_INT_ENABLE, 32'h0);
        // Enable lands at the access edge, irq one clock later
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        {pat, len} <= {16'hc000, 5'd3};
        repeat (2000) @(posedge clk_i);
        apb(1'b1, IDX_INT_CLEAR, 32'h1);
        apb(1'b0, IDX_INT_STATUS, 32'h0);
        `CHK(q[INT_UP], 1'b0)
        {pat, len} <= {16'hf00f, 5'd16};
        wait_st(INT_DN, 8000);
        `CHK(q[INT_UP], 1'b0)
        // E1 rate for the period check; the loop test runs at T1
        apb(1'b1, IDX_CTRL, 32'h4);
        apb(1'b1, IDX_INT_CLEAR, 32'h4);
        wait_st(INT_SEC, 500);
        b0 = bit_cnt;
        apb(1'b1, IDX_INT_CLEAR, 32'h4);
        wait_st(INT_SEC, 500);
        `CHK(bit_cnt - b0 inside {[SEC_E1 - 1:SEC_E1 + 1]}, 1'b1)
        apb(1'b0, IDX_RX_INFO_TWO, 32'h0);
        `CHK(q[INFO_SEC], 1'b1)
        apb(1'b0, IDX_RX_INFO_TWO, 32'h0);
        `CHK(q[INFO_SEC], 1'b0)
        apb(1'b1, IDX_CTRL, 32'h2);
        apb(1'b1, IDX_INT_CLEAR, 32'h1);
        {pat, len} <= {16'h8000, 5'd5};
        wait_st(INT_UP, 8000);
        repeat (960) @(posedge clk_i);
        `CHK(remote_loopback_o, 1'b0)
        wait_rl(1'b1);
        apb(1'b0, IDX_RX_INFO_TWO, 32'h0);
        `CHK(q[INFO_ARL], 1'b1)
        apb(1'b1, IDX_CTRL, 32'h0);
        repeat (3) @(posedge clk_i);
        `CHK(remote_loopback_o, 1'b0)
        apb(1'b1, IDX_CTRL, 32'h2);
        wait_rl(1'b1);
        {pat, len} <= {16'hf00f, 5'd16};
        repeat (960) @(posedge clk_i);
        `CHK(remote_loopback_o, 1'b1)
        wait_rl(1'b0);
        test_done();
    end
endmodule
